// [uiec_ep.sv]
// one in endpoint: control register state and its handshake choice
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ns
module uiec_ep #(
    parameter int  EP_NUM = 0
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // software write to this endpoint's control word
    input  wire logic        ctrl_wr,
    input  wire logic [31:0] ctrl_wdata,
    input  wire logic [3:0]  ctrl_sel,
    // software clear of event flags (write one)
    input  wire logic        flag_wr,
    input  wire logic [31:0] flag_wdata,
    // link and transfer engine events
    input  wire logic        bus_reset,
    input  wire logic        setup_rx,
    input  wire logic        setup_done,
    input  wire logic        xfer_done,
    input  wire logic        stop_done,
    input  wire logic        packet_sent,
    input  wire logic        frame_tick,
    input  wire logic        token_in,
    input  wire logic        nak_taken,
    // state
    output logic [31:0]      ctrl_rdata,
    output logic [31:0]      flag_rdata,
    output logic             armed,
    output logic [3:0]       fifo_num,
    output logic [1:0]       handshake
);
    typedef struct packed {
        logic [10:0]        mps;
        logic               active;
        logic               parity;
        logic               nak;
        uiec_pkg::uiec_type_t ep_type;
        logic               stall;
        logic [3:0]         fifo;
        logic               stop;
        logic               arm;
        logic               f_done;
        logic               f_stopped;
        logic               f_nake;
    } uiec_ep_state_t;
    uiec_ep_state_t st;
    uiec_ep_state_t next_st;
    logic is_iso;
    logic is_ctl;

    assign is_iso = (st.ep_type == uiec_pkg::UIEC_ISOCHRONOUS);
    assign is_ctl = (st.ep_type == uiec_pkg::UIEC_CONTROL);

    always_comb begin
        next_st = st;
        if (ctrl_wr && ctrl_sel[1]) begin
            next_st.active = ctrl_wdata[uiec_pkg::ACTIVE_BIT]; // RL2
        end
        if (ctrl_wr && ctrl_sel[0]) begin
            next_st.mps[7:0] = ctrl_wdata[7:0]; // RL1
        end
        if (ctrl_wr && ctrl_sel[1]) begin
            next_st.mps[10:8] = ctrl_wdata[uiec_pkg::MPS_W-1:8]; // RL1
        end
        if (ctrl_wr && ctrl_sel[2]) begin
            next_st.ep_type = uiec_pkg::uiec_type_t'(ctrl_wdata[uiec_pkg::TYPE_LSB +: 2]); // RL7
            next_st.stall   = ctrl_wdata[uiec_pkg::STALL_BIT]; // RL8
            next_st.fifo[1:0] = ctrl_wdata[uiec_pkg::FIFO_LSB +: 2];
        end
        if (ctrl_wr && ctrl_sel[3]) begin
            next_st.fifo[3:2] = ctrl_wdata[uiec_pkg::FIFO_LSB+2 +: 2]; // RL10
            if (ctrl_wdata[uiec_pkg::NAK_CLR_BIT]) begin
                next_st.nak    = 1'b0; // RL11
                next_st.f_nake = 1'b0; // RL20
            end
            if (ctrl_wdata[uiec_pkg::NAK_SET_BIT]) begin
                next_st.nak = 1'b1; // RL11
            end
            // even and toggle share one flop; the type picks the meaning
            if (ctrl_wdata[uiec_pkg::EVEN_BIT]) begin
                next_st.parity = 1'b0; // RL12 RL13
            end
            if (ctrl_wdata[uiec_pkg::ODD_BIT]) begin
                next_st.parity = 1'b1; // RL14
            end
            // stop only takes hold on an armed endpoint; software must not ask otherwise
            if (ctrl_wdata[uiec_pkg::STOP_BIT] && st.arm) begin
                next_st.stop = 1'b1; // RL15 RL17
            end
            if (ctrl_wdata[uiec_pkg::ARM_BIT]) begin
                next_st.arm = 1'b1; // RL18
            end
        end
        if (flag_wr) begin
            if (flag_wdata[0]) next_st.f_done = 1'b0;
            if (flag_wdata[1]) next_st.f_stopped = 1'b0;
            if (flag_wdata[uiec_pkg::NAKE_FLAG_BIT]) next_st.f_nake = 1'b0;
        end
        // hardware events win over software clears
        if (packet_sent && !is_iso && !is_ctl) begin
            next_st.parity = ~st.parity; // RL4
        end
        if (frame_tick && is_iso) begin
            next_st.parity = ~st.parity; // RL3
        end
        if (setup_rx && is_ctl) begin
            next_st.stall = 1'b1; // RL9
        end
        if (nak_taken && st.nak) begin
            next_st.f_nake = 1'b1;
        end
        if (xfer_done) begin
            next_st.f_done = 1'b1;
            next_st.arm    = 1'b0; // RL19
        end
        if (setup_done) begin
            next_st.arm = 1'b0; // RL19
        end
        if (stop_done && st.stop) begin
            // stop bit drops in the same edge as the flag rises, never after it
            next_st.stop      = 1'b0; // RL16
            next_st.f_stopped = 1'b1;
            next_st.arm       = 1'b0; // RL19
        end
        if (bus_reset && (EP_NUM != 0)) begin
            next_st.active = 1'b0; // RL2
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        handshake = uiec_pkg::UIEC_HS_NONE;
        if (setup_rx) begin
            handshake = uiec_pkg::UIEC_HS_ACK; // RL6
        end else if (token_in) begin
            if (st.stall && !is_ctl && !is_iso) begin
                handshake = uiec_pkg::UIEC_HS_STALL; // RL8
            end else if (st.nak || !st.arm || st.stop) begin
                handshake = uiec_pkg::UIEC_HS_NAK; // RL5
            end else begin
                handshake = uiec_pkg::UIEC_HS_ACK; // RL5
            end
        end
    end

    // reserved and strobe bits read zero
    assign ctrl_rdata = {st.arm, st.stop, 4'h0, st.fifo, st.stall, 1'b0, st.ep_type,
                         st.nak, st.parity, st.active, 4'h0, st.mps}; // RL21
    assign flag_rdata = {25'h0000000, st.f_nake, 4'h0, st.f_stopped, st.f_done};
    assign armed      = st.arm && !st.stop;
    assign fifo_num   = st.fifo;
endmodule // uiec_ep

// [uiec_host_model.sv]
// partner: usb host and transfer engine issuing tokens and events
`timescale 1ns/1ns
module uiec_host_model (
    // clock
    input  wire logic       clk,
    // answer from the endpoints
    input  wire logic [1:0] handshake,
    // {frame, bus reset, nak, token, sent, stop, xfer, setup done, setup}
    output logic [8:0]      ev,
    output logic [2:0]      ep,
    output logic [1:0]      seen_hs
);
    initial begin
        ev = 9'h000;
        ep = 3'h0;
        seen_hs = 2'h0;
    end
    // handshake is combinational; it is taken at the rising edge that ends the pulse
    task send(input logic [8:0] k, input logic [2:0] e);
        @(posedge clk);
        ev <= k;
        ep <= e;
        @(posedge clk);
        seen_hs = handshake;
        ev <= 9'h000;
        // number is meaningless between events, so never leave it standing
        ep <= ~e;
    endtask
endmodule // uiec_host_model

// [uiec_pkg.sv]
// package: offsets, field positions and encodings of the in endpoint control block
package uiec_pkg;
    localparam int          EP_COUNT        = 8;
    localparam logic [11:0] CTRL_BASE       = 12'h900;
    localparam logic [11:0] CTRL_STRIDE     = 12'h020;
    localparam logic [11:0] EPINT_BASE      = 12'h908;
    localparam logic [11:0] EV_OFFSET       = 12'h9fc;
    localparam int          MPS_LSB         = 0;
    localparam int          MPS_W           = 11;
    localparam int          ACTIVE_BIT      = 15;
    localparam int          PARITY_BIT      = 16;
    localparam int          NAK_BIT         = 17;
    localparam int          TYPE_LSB        = 18;
    localparam int          STALL_BIT       = 21;
    localparam int          FIFO_LSB        = 22;
    localparam int          NAK_CLR_BIT     = 26;
    localparam int          NAK_SET_BIT     = 27;
    localparam int          EVEN_BIT        = 28;
    localparam int          ODD_BIT         = 29;
    localparam int          STOP_BIT        = 30;
    localparam int          ARM_BIT         = 31;
    localparam int          NAKE_FLAG_BIT   = 6;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] EPINT_RESET     = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;
    typedef enum logic [1:0] {
        UIEC_CONTROL,
        UIEC_ISOCHRONOUS,
        UIEC_BULK,
        UIEC_INTERRUPT
    } uiec_type_t;
    typedef enum logic [1:0] {
        UIEC_HS_NONE,
        UIEC_HS_ACK,
        UIEC_HS_NAK,
        UIEC_HS_STALL
    } uiec_hs_t;
endpackage

// [uiec_top.sv]
// top: wishbone register file for the in endpoint control words of all endpoints
//
// Functional notes
// RL1: eleven-bit writable largest packet size per endpoint.
// RL2: active flag at bit 15; bus reset clears it except endpoint 0.
// RL3: isochronous endpoints show frame parity at bit 16.
// RL4: bulk and interrupt endpoints show data toggle at bit 16.
// RL5: bit 17 shows NAK state; when set every token gets NAK, except that a stalled bulk/interrupt endpoint answers STALL.
// RL6: a SETUP packet is always answered with ACK.
// RL7: bits 19:18 select control, isochronous, bulk or interrupt.
// RL8: stall bit 21 makes bulk/interrupt endpoints answer STALL; software clears it.
// RL9: control endpoints set bit 21 on a received SETUP token.
// RL10: software gives every used endpoint its own transmit FIFO number.
// RL11: write bit 26 clears NAK state; write bit 27 sets it.
// RL12: bit 28 write forces toggle to DATA0 on bulk/interrupt endpoints.
// RL13: bit 28 write forces even parity on isochronous endpoints.
// RL14: bit 29 write forces odd parity.
// RL15: setting stop bit 30 halts transmission on the endpoint.
// RL16: stop bit clears before the endpoint-stopped flag rises; here both change on the same edge.
// RL17: software sets the stop bit only on an armed endpoint.
// RL18: setting arm bit 31 starts transmission.
// RL19: arm clears on setup done, endpoint stopped or transfer done.
// RL20: NAK-clear write also clears the NAK-effective flag.
// RL21: reserved bits and strobe bits read as zero.
`timescale 1ns/1ns
module uiec_top #(
    parameter int EP_NUM_COUNT = uiec_pkg::EP_COUNT
) (
    // clock and reset
    input  wire logic                      CLK,
    input  wire logic                      RST,
    // wishbone slave
    input  wire logic                      CYC_I,
    input  wire logic                      STB_I,
    input  wire logic                      WE_I,
    input  wire logic [11:0]               ADR_I,
    input  wire logic [3:0]                SEL_I,
    input  wire logic [31:0]               DAT_I,
    output logic [31:0]                    DAT_O,
    output logic                           ACK_O,
    // link events, one pulse per event, tagged by endpoint except bus reset and frame tick
    input  wire logic                      BUS_RESET,
    input  wire logic [2:0]                EVENT_EP,
    input  wire logic                      SETUP_RX,
    input  wire logic                      SETUP_DONE,
    input  wire logic                      XFER_DONE,
    input  wire logic                      STOP_DONE,
    input  wire logic                      PACKET_SENT,
    input  wire logic                      TOKEN_IN,
    input  wire logic                      NAK_TAKEN,
    input  wire logic                      FRAME_TICK,
    // answers to the link and transfer engine
    output logic [1:0]                     HANDSHAKE,
    output logic [EP_NUM_COUNT-1:0]        ARMED,
    output logic [4*EP_NUM_COUNT-1:0]      FIFO_NUM
);
    typedef struct packed {
        logic [31:0] rdata;
    } uiec_top_state_t;
    uiec_top_state_t st;
    uiec_top_state_t next_st;

    logic                  ack;
    logic                  wr_pulse;
    logic                  rd_pulse;
    logic [31:0]           ctrl_rd [EP_NUM_COUNT];
    logic [31:0]           flag_rd [EP_NUM_COUNT];
    logic [1:0]            hs      [EP_NUM_COUNT];
    logic [EP_NUM_COUNT-1:0] hit_ctrl;
    logic [EP_NUM_COUNT-1:0] hit_flag;

    ////////////////////////////////////////////////////////////////////////////////
    uiec_wb_slave u_wb (
        .clk      (CLK),
        .rst      (RST),
        .cyc      (CYC_I),
        .stb      (STB_I),
        .we       (WE_I),
        .ack      (ack),
        .wr_pulse (wr_pulse),
        .rd_pulse (rd_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < EP_NUM_COUNT; g = g + 1) begin : g_ep
            logic sel_ev;
            assign sel_ev      = (EVENT_EP == 3'(g));
            assign hit_ctrl[g] = (ADR_I == uiec_pkg::CTRL_BASE + 12'(g) * uiec_pkg::CTRL_STRIDE);
            assign hit_flag[g] = (ADR_I == uiec_pkg::EPINT_BASE + 12'(g) * uiec_pkg::CTRL_STRIDE);
            uiec_ep #(
                .EP_NUM (g)
            ) u_ep (
                .clk         (CLK),
                .rst         (RST),
                .ctrl_wr     (wr_pulse && hit_ctrl[g]),
                .ctrl_wdata  (DAT_I),
                .ctrl_sel    (SEL_I),
                .flag_wr     (wr_pulse && hit_flag[g]),
                .flag_wdata  (DAT_I),
                .bus_reset   (BUS_RESET), // RL2
                .setup_rx    (SETUP_RX && sel_ev),
                .setup_done  (SETUP_DONE && sel_ev),
                .xfer_done   (XFER_DONE && sel_ev),
                .stop_done   (STOP_DONE && sel_ev),
                .packet_sent (PACKET_SENT && sel_ev),
                .frame_tick  (FRAME_TICK),
                .token_in    (TOKEN_IN && sel_ev),
                .nak_taken   (NAK_TAKEN && sel_ev),
                .ctrl_rdata  (ctrl_rd[g]),
                .flag_rdata  (flag_rd[g]),
                .armed       (ARMED[g]),
                .fifo_num    (FIFO_NUM[4*g +: 4]),
                .handshake   (hs[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // read data is latched while the request is pending so it stands with ack
    always_comb begin
        next_st = st;
        if (CYC_I && STB_I && !ack) begin
            next_st.rdata = uiec_pkg::UNMAPPED_READ;
            for (int i = 0; i < EP_NUM_COUNT; i++) begin
                if (hit_ctrl[i]) begin
                    next_st.rdata = ctrl_rd[i];
                end else if (hit_flag[i]) begin
                    next_st.rdata = flag_rd[i];
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign DAT_O     = st.rdata;
    assign ACK_O     = ack;
    assign HANDSHAKE = hs[EVENT_EP]; // RL5 RL6 RL8
endmodule // uiec_top

// [uiec_top_props.sv]
// checker: bus timing, handshake choice and arm state of the in endpoint block
`timescale 1ns/1ns
module uiec_top_props #(
    parameter int EP_NUM_COUNT = 8
) (
    // watched ports
    input wire logic                      CLK,
    input wire logic                      RST,
    input wire logic                      CYC_I,
    input wire logic                      STB_I,
    input wire logic                      WE_I,
    input wire logic [11:0]               ADR_I,
    input wire logic [3:0]                SEL_I,
    input wire logic [31:0]               DAT_I,
    input wire logic                      ACK_O,
    input wire logic                      BUS_RESET,
    input wire logic [2:0]                EVENT_EP,
    input wire logic                      SETUP_RX,
    input wire logic                      SETUP_DONE,
    input wire logic                      XFER_DONE,
    input wire logic                      STOP_DONE,
    input wire logic                      TOKEN_IN,
    input wire logic [1:0]                HANDSHAKE,
    input wire logic [EP_NUM_COUNT-1:0]   ARMED,
    input wire logic [4*EP_NUM_COUNT-1:0] FIFO_NUM
);
    // a control write lands at the edge where ack is seen
    wire ctrl_wr = CYC_I && STB_I && WE_I && ACK_O && ADR_I[11:8] == 4'h9 && ADR_I[4:0] == 5'h00;
    wire done_ev = SETUP_DONE || XFER_DONE || STOP_DONE;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
    ack_latency_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack late");
    ack_cause_a: assert property (!(CYC_I && STB_I) |=> !ACK_O) else $error("ack without request");
    setup_ack_a: assert property (SETUP_RX && !TOKEN_IN |-> HANDSHAKE == 2'h1)
        else $error("setup not acked");
    hs_idle_a: assert property (!SETUP_RX && !TOKEN_IN |-> HANDSHAKE == 2'h0) else $error("stray handshake");
    ev_disarm_a: assert property (done_ev |=> !ARMED[$past(EVENT_EP)])
        else $error("arm kept after event");
    stop_disarm_a: assert property (ctrl_wr && SEL_I[3] && DAT_I[30] |=> !ARMED[$past(ADR_I[7:5])])
        else $error("stop ignored");
    arm_start_a: assert property (ctrl_wr && SEL_I[3] && DAT_I[31] && !DAT_I[30] && !done_ev && !BUS_RESET
        |=> ARMED[$past(ADR_I[7:5])]) else $error("arm ignored");
    fifo_map_a: assert property (ctrl_wr && SEL_I[3:2] == 2'h3
        |=> FIFO_NUM[4*$past(ADR_I[7:5]) +: 4] == $past(DAT_I[25:22])) else $error("fifo number wrong");
endmodule // uiec_top_props

bind uiec_top uiec_top_props #(.EP_NUM_COUNT(EP_NUM_COUNT)) u_props (.CLK(CLK), .RST(RST), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .ACK_O(ACK_O),
    .BUS_RESET(BUS_RESET), .EVENT_EP(EVENT_EP), .SETUP_RX(SETUP_RX), .SETUP_DONE(SETUP_DONE),
    .XFER_DONE(XFER_DONE), .STOP_DONE(STOP_DONE), .TOKEN_IN(TOKEN_IN), .HANDSHAKE(HANDSHAKE),
    .ARMED(ARMED), .FIFO_NUM(FIFO_NUM));

// [uiec_top_tb.sv]
// testbench: register and event sequences for the in endpoint control block
`timescale 1ns/1ns
module uiec_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat, fnum, q;
    logic        ack;
    logic [1:0]  hs, seen;
    logic [7:0]  armed;
    logic [8:0]  ev;
    logic [2:0]  eep;
    logic [31:0] base [8];
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;
    localparam logic [31:0] TGL = 32'h1 << 16, NAK = 32'h1 << 17, STL = 32'h1 << 21, CLR = 32'h1 << 26;
    localparam logic [31:0] SET = 32'h1 << 27, EVN = 32'h1 << 28, ODD = 32'h1 << 29;
    localparam logic [31:0] STP = 32'h1 << 30, ARM = 32'h1 << 31;
    localparam logic [8:0]  SRX = 9'h001, SDN = 9'h002, XDN = 9'h004, SDONE = 9'h008, SNT = 9'h010;
    localparam logic [8:0]  TOK = 9'h020, NKT = 9'h040, BRS = 9'h080, FRM = 9'h100;

    always #2 clk = ~clk;

    uiec_top u_dut (.CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
        .DAT_I(dat), .DAT_O(rdat), .ACK_O(ack), .BUS_RESET(ev[7]), .EVENT_EP(eep), .SETUP_RX(ev[0]),
        .SETUP_DONE(ev[1]), .XFER_DONE(ev[2]), .STOP_DONE(ev[3]), .PACKET_SENT(ev[4]), .TOKEN_IN(ev[5]),
        .NAK_TAKEN(ev[6]), .FRAME_TICK(ev[8]), .HANDSHAKE(hs), .ARMED(armed), .FIFO_NUM(fnum));
    uiec_host_model u_host (.clk(clk), .handshake(hs), .ev(ev), .ep(eep), .seen_hs(seen));

    ////////////////////////////////////////////////////////////////
    task final_report();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            final_report();
        end
    end
    task check(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= d;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 64);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (t >= 64) begin
            n_mismatch++;
            final_report();
        end
    endtask
    task wr(input int n, input logic [31:0] d);
        wb(uiec_pkg::CTRL_BASE + 12'(n) * uiec_pkg::CTRL_STRIDE, 1'b1, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        check(q, e);
    endtask
    function automatic logic [11:0] cw(input int n, input logic [11:0] b);
        return b + 12'(n) * uiec_pkg::CTRL_STRIDE;
    endfunction
    task arm_is(input int n, input logic e);
        @(negedge clk);
        check({31'h0, armed[n]}, {31'h0, e});
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(cw(7, uiec_pkg::CTRL_BASE), uiec_pkg::CTRL_RESET);
        rd(cw(7, uiec_pkg::EPINT_BASE), uiec_pkg::EPINT_RESET);
        for (int n = 0; n < 8; n++) begin
            base[n] = {6'h00, 4'(n), 2'b00, 2'(n), 3'b001, 4'h0, 11'h7ff - 11'(n)};
            wr(n, base[n] | 32'h0010_7800);
            rd(cw(n, uiec_pkg::CTRL_BASE), base[n]);
            @(negedge clk);
            check({28'h0, fnum[4*n +: 4]}, 32'(n));
        end
        rd(12'h0a0, uiec_pkg::UNMAPPED_READ);
        wr(1, base[1] | SET);
        rd(cw(1, uiec_pkg::CTRL_BASE), base[1] | NAK);
        u_host.send(TOK, 3'h1);
        check({30'h0, seen}, 32'h2);
        u_host.send(NKT, 3'h1);
        rd(cw(1, uiec_pkg::EPINT_BASE), 32'h40);
        wr(0, base[0] | SET);
        u_host.send(SRX, 3'h0);
        check({30'h0, seen}, 32'h1);
        rd(cw(0, uiec_pkg::CTRL_BASE), base[0] | NAK | STL);
        wr(1, base[1] | CLR);
        rd(cw(1, uiec_pkg::CTRL_BASE), base[1]);
        rd(cw(1, uiec_pkg::EPINT_BASE), 32'h0);
        // stall outlives tokens and goes only by software
        wr(2, base[2] | STL);
        u_host.send(TOK, 3'h2);
        check({30'h0, seen}, 32'h3);
        rd(cw(2, uiec_pkg::CTRL_BASE), base[2] | STL);
        wr(2, base[2]);
        rd(cw(2, uiec_pkg::CTRL_BASE), base[2]);
        u_host.send(SNT, 3'h2);
        rd(cw(2, uiec_pkg::CTRL_BASE), base[2] | TGL);
        wr(2, base[2] | EVN);
        rd(cw(2, uiec_pkg::CTRL_BASE), base[2]);
        u_host.send(FRM, 3'h0);
        rd(cw(1, uiec_pkg::CTRL_BASE), base[1] | TGL);
        wr(1, base[1] | EVN);
        rd(cw(1, uiec_pkg::CTRL_BASE), base[1]);
        wr(1, base[1] | ODD);
        rd(cw(1, uiec_pkg::CTRL_BASE), base[1] | TGL);
        wr(3, base[3] | ARM);
        arm_is(3, 1'b1);
        // armed, no nak, no stall: a token gets a data answer
        u_host.send(TOK, 3'h3);
        check({30'h0, seen}, 32'h1);
        wr(3, base[3] | STP);
        arm_is(3, 1'b0);
        rd(cw(3, uiec_pkg::CTRL_BASE), base[3] | ARM | STP);
        u_host.send(SDONE, 3'h3);
        rd(cw(3, uiec_pkg::CTRL_BASE), base[3]);
        rd(cw(3, uiec_pkg::EPINT_BASE), 32'h2);
        foreach (base[k]) if (k < 2) begin
            wr(3, base[3] | ARM);
            arm_is(3, 1'b1);
            u_host.send(k == 0 ? SDN : XDN, 3'h3);
            arm_is(3, 1'b0);
        end
        // transfer done and stopped flags stand until software writes ones
        rd(cw(3, uiec_pkg::EPINT_BASE), 32'h3);
        wb(cw(3, uiec_pkg::EPINT_BASE), 1'b1, 32'h3);
        rd(cw(3, uiec_pkg::EPINT_BASE), 32'h0);
        // stop on an idle endpoint is refused
        wr(4, base[4] | STP);
        rd(cw(4, uiec_pkg::CTRL_BASE), base[4]);
        u_host.send(BRS, 3'h0);
        wb(cw(0, uiec_pkg::CTRL_BASE), 1'b0, 32'h0);
        check({31'h0, q[15]}, 32'h1);
        wb(cw(5, uiec_pkg::CTRL_BASE), 1'b0, 32'h0);
        check({31'h0, q[15]}, 32'h0);
        final_report();
    end
endmodule // uiec_top_tb

// [uiec_wb_slave.sv]
// classic wishbone slave front end: one-cycle ack, decode left to the owner
`timescale 1ns/1ns
module uiec_wb_slave (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // wishbone
    input  wire logic        cyc,
    input  wire logic        stb,
    input  wire logic        we,
    output logic             ack,
    // access strobes for the register file
    output logic             wr_pulse,
    output logic             rd_pulse
);
    typedef struct packed {
        logic ack;
    } uiec_wb_state_t;
    uiec_wb_state_t st;
    uiec_wb_state_t next_st;

    always_comb begin
        next_st = st;
        // ack drops in the cycle after it was given, so a held request is not answered in two cycles running
        next_st.ack = cyc && stb && !st.ack;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ack      = st.ack;
    assign wr_pulse = st.ack && we;
    assign rd_pulse = st.ack && !we;
endmodule // uiec_wb_slave
